// >>> dvt_enc_if.sv
// Interface carrying one channel's pixel, control and symbol between the map and an encoder
`timescale 1ns/1ps
`default_nettype none
interface dvt_enc_if;
    logic [7:0] data; // Colour byte for active video
    logic de; // High during active video
    logic [1:0] ctrl; // Control pair {c1, c0} for blanking
    logic load; // One-cycle strobe: encode one pixel
    logic clear; // Held high while powered down
    logic [9:0] sym; // Registered link symbol

    // Side that feeds pixels
    modport src (output data, output de, output ctrl, output load, output clear, input sym);
    // Encoder side
    modport enc (input data, input de, input ctrl, input load, input clear, output sym);
endinterface
`default_nettype wire

// >>> dvt_pkg.sv
// Constants, symbol tables and helper functions for the DVI power-down and channel map block
`default_nettype none
package dvt_pkg;

    // Widths of the pixel path and the link symbols
    localparam int COLOR_W = 8;
    localparam int SYM_W = 10;
    localparam int CTRL_W = 2;
    localparam int DISP_W = 6;

    // Synchroniser reset values
    localparam logic SYNC_RST = 1'b0;

    // Serial power bit reset value: low means powered down
    localparam logic CFG_RUN_RST = 1'b0;

    // Control tokens sent during blanking, indexed by {c1, c0}
    localparam logic [9:0] TOKEN_00 = 10'h354;
    localparam logic [9:0] TOKEN_01 = 10'h0ab;
    localparam logic [9:0] TOKEN_10 = 10'h154;
    localparam logic [9:0] TOKEN_11 = 10'h2ab;

    // Quiet symbol while powered down
    localparam logic [9:0] SYM_IDLE = 10'h000;
    localparam logic signed [5:0] DISP_ZERO = 6'sh00;
    localparam logic signed [5:0] DISP_TWO = 6'sh02;

    // Transition-minimising thresholds
    localparam logic [3:0] ONES_HALF = 4'h4;
    localparam logic [3:0] ONES_ALL = 4'h8;

    // Control token lookup, shared by the encoders and the checks
    function automatic logic [9:0] ctrl_token(input logic [1:0] c);
        logic [9:0] t;
        t = TOKEN_00;
        case (c)
            2'h0: t = TOKEN_00;
            2'h1: t = TOKEN_01;
            2'h2: t = TOKEN_10;
            default: t = TOKEN_11;
        endcase
        return t;
    endfunction

    // Count of set bits in a byte
    function automatic logic [3:0] ones8(input logic [7:0] d);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, d[i]};
        end
        return n;
    endfunction

    // Recovers the pixel byte from an active-video symbol
    function automatic logic [7:0] sym_decode(input logic [9:0] q);
        logic [7:0] d;
        logic [7:0] o;
        d = q[9] ? ~q[7:0] : q[7:0];
        o = 8'h00;
        o[0] = d[0];
        for (int i = 1; i < 8; i++) begin
            o[i] = q[8] ? (d[i] ^ d[i-1]) : ~(d[i] ^ d[i-1]);
        end
        return o;
    endfunction

endpackage
`default_nettype wire

// >>> dvt_powerdown_channel_map.sv
// Power-down control, channel mapping and link clock drive for the DVI transmitter core
`timescale 1ns/1ps
`default_nettype none
module dvt_powerdown_channel_map (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Power and mode pins
    input wire logic power_down_n_in,
    input wire logic serial_config_select_in,
    // Serial configuration port (same clock domain)
    input wire logic cfg_wr_in,
    input wire logic cfg_run_in,
    input wire logic cfg_reset_in,
    output logic cfg_run_out,
    // Pixel input pins
    input wire logic link_clock_in,
    input wire logic [dvt_pkg::COLOR_W-1:0] blue_in,
    input wire logic [dvt_pkg::COLOR_W-1:0] green_in,
    input wire logic [dvt_pkg::COLOR_W-1:0] red_in,
    input wire logic de_in,
    input wire logic hsync_in,
    input wire logic vsync_in,
    input wire logic [3:1] aux_control_bits_in,
    // Link outputs
    output logic [dvt_pkg::SYM_W-1:0] link_channel_zero_out,
    output logic [dvt_pkg::SYM_W-1:0] link_channel_one_out,
    output logic [dvt_pkg::SYM_W-1:0] link_channel_two_out,
    output logic link_clock_pair_p_out,
    output logic link_clock_pair_n_out,
    output logic link_oe_out,
    // Status
    output logic powered_down_out
);
    import dvt_pkg::*;

    localparam int PIN_W = 3 * COLOR_W + 9; // All pins passing through the synchroniser

    logic [PIN_W-1:0] pin_s1_r; // First stage, read only by the second
    logic [PIN_W-1:0] pin_s2_r; // Second stage, safe to use
    logic pdn_s; // Synced power-down pin
    logic sel_s; // Synced serial select pin
    logic lclk_s; // Synced link clock
    // Decoded views of the synchronised pin word
    logic [7:0] blue_s; // Blue byte
    logic [7:0] green_s; // Green byte
    logic [7:0] red_s; // Red byte
    logic de_s; // Active video
    logic hs_s; // Horizontal sync
    logic vs_s; // Vertical sync
    logic [3:1] aux_s; // Aux control bits
    logic lclk_d_r; // Previous link clock sample
    logic sel_d_r; // Previous select sample
    logic sel_rise; // Serial port just enabled
    logic pix_edge; // Rising link clock edge
    logic cfg_run_r; // Serial power bit: high is normal operation
    logic pd_eff; // Requested power-down
    logic pd_r; // Power-down state in force
    logic clk_p_r; // Positive clock leg
    logic clk_n_r; // Negative clock leg
    logic oe_r; // Link driven

    dvt_enc_if ch_if [3] ();

    // Two-flop synchroniser for every pin from outside the clock domain
    // Costs two cycles on every pin, but no metastable value ever reaches the logic
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pin_s1_r <= {PIN_W{SYNC_RST}};
            pin_s2_r <= {PIN_W{SYNC_RST}};
        end else begin
            pin_s1_r <= {power_down_n_in, serial_config_select_in, link_clock_in, blue_in, green_in, red_in,
                         de_in, hsync_in, vsync_in, aux_control_bits_in};
            pin_s2_r <= pin_s1_r;
        end
    end

    assign {pdn_s, sel_s, lclk_s, blue_s, green_s, red_s, de_s, hs_s, vs_s, aux_s} = pin_s2_r;

    // Edge detectors work only on second-stage samples
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            lclk_d_r <= SYNC_RST;
            sel_d_r <= SYNC_RST;
        end else begin
            lclk_d_r <= lclk_s;
            sel_d_r <= sel_s;
        end
    end

    assign sel_rise = sel_s && !sel_d_r;
    assign pix_edge = lclk_s && !lclk_d_r;

    // Serial power bit; enabling the serial port, or resetting it in serial mode, leaves the part powered down
    always_ff @(posedge clk_in) begin
        if (!rstn_in || cfg_reset_in || sel_rise) begin
            cfg_run_r <= CFG_RUN_RST;
        end else if (cfg_wr_in) begin
            cfg_run_r <= cfg_run_in; // Written even while powered down
        end
    end

    assign cfg_run_out = cfg_run_r;

    // Power source: the register in serial mode, the active-low pin when strapped
    // The pin is ignored in serial mode, so its board strap cannot fight the register
    always_comb begin
        if (sel_s) begin
            pd_eff = !cfg_run_r; // Pin ignored
        end else begin
            pd_eff = !pdn_s;
        end
    end

    // Power state register; starts powered down so the link stays quiet through reset
    // One cycle of latency keeps the state a clean flop output for every consumer
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pd_r <= !CFG_RUN_RST; // Follows the power bit's reset value
        end else begin
            pd_r <= pd_eff;
        end
    end

    assign powered_down_out = pd_r;

    // Channel feeds: blanking controls per channel, encoders held clear while down
    always_comb begin
        ch_if[0].data = blue_s;
        ch_if[0].ctrl = {vs_s, hs_s};
        ch_if[1].data = green_s;
        ch_if[1].ctrl = {1'b0, aux_s[1]};
        ch_if[2].data = red_s;
        ch_if[2].ctrl = aux_s[3:2];
    end

    // Three identical encoders, one per link channel
    // All three share one load strobe, so the channels never drift apart by a pixel
    for (genvar g = 0; g < 3; g++) begin : g_ch
        assign ch_if[g].de = de_s;
        assign ch_if[g].load = pix_edge && !pd_r; // No encoding while down
        assign ch_if[g].clear = pd_r;
        dvt_tmds_enc u_enc (
            .clk_in (clk_in),
            .rstn_in (rstn_in),
            .ch (ch_if[g])
        );
    end

    assign link_channel_zero_out = ch_if[0].sym;
    assign link_channel_one_out = ch_if[1].sym;
    assign link_channel_two_out = ch_if[2].sym;

    // Link clock pair follows the pixel clock; both legs parked low while down
    // Legs update on the same edge as the symbols, so data and clock stay aligned
    always_ff @(posedge clk_in) begin
        if (!rstn_in || pd_r) begin
            clk_p_r <= 1'b0;
            clk_n_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            clk_p_r <= lclk_s;
            clk_n_r <= !lclk_s;
            oe_r <= 1'b1;
        end
    end

    assign link_clock_pair_p_out = clk_p_r;
    assign link_clock_pair_n_out = clk_n_r;
    assign link_oe_out = oe_r;

    // Checks on the power state and channel mapping
    // Strapped mode: the pin alone decides, one cycle after its synchronised value
    a_pin_low_down: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (!sel_s && !pdn_s) |=> pd_r) else $error("pin low did not power down");
    a_pin_high_runs: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (!sel_s && pdn_s) |=> !pd_r) else $error("pin high did not run");
    // Serial mode: the register bit decides and the pin is ignored
    a_serial_rules: assert property (@(posedge clk_in) disable iff (!rstn_in)
        sel_s |=> (pd_r == !$past(cfg_run_r))) else $error("serial mode not obeyed");
    // A serial reset or a fresh select clears the bit; the part is down a cycle later unless strapped again
    a_cfg_reset_low: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (cfg_reset_in || sel_rise) |=> (!cfg_run_r ##1 (pd_r || !$past(sel_s))))
        else $error("power bit not cleared");
    // Enabling the serial port always starts from the powered-down value
    a_select_clears: assert property (@(posedge clk_in) disable iff (!rstn_in)
        sel_rise |=> !cfg_run_r) else $error("power bit not cleared on select");
    // Powered down: every link output is quiet
    a_down_quiet: assert property (@(posedge clk_in) disable iff (!rstn_in)
        pd_r |=> (!link_oe_out && link_channel_zero_out == SYM_IDLE && link_channel_one_out == SYM_IDLE
                  && link_channel_two_out == SYM_IDLE && !link_clock_pair_p_out && !link_clock_pair_n_out))
        else $error("link active while down");
    // Powered down: the serial port still takes writes
    a_down_io_live: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (pd_r && cfg_wr_in && !cfg_reset_in && !sel_rise) |=> (cfg_run_r == $past(cfg_run_in)))
        else $error("serial write lost while down");
    // Running: the clock pair mirrors the synchronised pixel clock
    a_clock_follows: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !pd_r |=> (link_clock_pair_p_out == $past(lclk_s) && link_clock_pair_n_out == !$past(lclk_s)))
        else $error("link clock pair wrong");
    // Channel map: tokens in blanking, decodable pixel bytes in active video
    a_ch0_map: assert property (@(posedge clk_in) disable iff (!rstn_in || pd_r)
        pix_edge |=> (link_channel_zero_out == ($past(de_s) ? link_channel_zero_out : ctrl_token($past({vs_s, hs_s}))))
        && (!$past(de_s) || sym_decode(link_channel_zero_out) == $past(blue_s))) else $error("channel zero map");
    a_ch1_map: assert property (@(posedge clk_in) disable iff (!rstn_in || pd_r)
        pix_edge |=> (link_channel_one_out == ($past(de_s) ? link_channel_one_out : ctrl_token({1'b0, $past(aux_s[1])})))
        && (!$past(de_s) || sym_decode(link_channel_one_out) == $past(green_s))) else $error("channel one map");
    a_ch2_map: assert property (@(posedge clk_in) disable iff (!rstn_in || pd_r)
        pix_edge |=> (link_channel_two_out == ($past(de_s) ? link_channel_two_out : ctrl_token($past(aux_s[3:2]))))
        && (!$past(de_s) || sym_decode(link_channel_two_out) == $past(red_s))) else $error("channel two map");

    // Main scenarios
    c_wake_by_pin: cover property (@(posedge clk_in) disable iff (!rstn_in) !sel_s && $fell(pd_r));
    c_wake_by_serial: cover property (@(posedge clk_in) disable iff (!rstn_in) sel_s && $fell(pd_r));
    c_active_pixel: cover property (@(posedge clk_in) disable iff (!rstn_in) pix_edge && de_s && !pd_r);
    c_blank_pixel: cover property (@(posedge clk_in) disable iff (!rstn_in) pix_edge && !de_s && !pd_r);
    c_serial_reset: cover property (@(posedge clk_in) disable iff (!rstn_in) cfg_reset_in && sel_s);

endmodule
`default_nettype wire

// >>> dvt_powerdown_channel_map_test.sv
// Self-checking bench for the power-down and channel map block
`timescale 1ns/1ps
`default_nettype none
module dvt_powerdown_channel_map_test;
    import dvt_pkg::*;
    logic clk, rstn, pdn, sel, cfg_wr, cfg_run, cfg_rst, cfg_run_o; // Control pins and readback
    logic lclk, de, hs, vs, ckp, ckn, oe, pd; // Pixel strobes and link status
    logic [2:0] aux; // Aux control bits three down to one
    logic [7:0] blue, green, red, rx_b, rx_g, rx_r; // Pixels in and decoded
    logic [9:0] ch0, ch1, ch2, rx0, rx1, rx2; // Symbols sent and captured
    logic [15:0] rx_cnt; // Pixels captured by the receiver
    int fail_count = 0;
    int tests_run = 0;

    dvt_powerdown_channel_map u_dvt_powerdown_channel_map (.clk_in(clk), .rstn_in(rstn),
        .power_down_n_in(pdn), .serial_config_select_in(sel), .cfg_wr_in(cfg_wr), .cfg_run_in(cfg_run),
        .cfg_reset_in(cfg_rst), .cfg_run_out(cfg_run_o), .link_clock_in(lclk), .blue_in(blue),
        .green_in(green), .red_in(red), .de_in(de), .hsync_in(hs), .vsync_in(vs), .aux_control_bits_in(aux),
        .link_channel_zero_out(ch0), .link_channel_one_out(ch1), .link_channel_two_out(ch2),
        .link_clock_pair_p_out(ckp), .link_clock_pair_n_out(ckn), .link_oe_out(oe), .powered_down_out(pd));
    dvt_rx_model u_dvt_rx_model (.clk_in(clk), .ch0_in(ch0), .ch1_in(ch1), .ch2_in(ch2), .clk_p_in(ckp),
        .oe_in(oe), .sym0_out(rx0), .sym1_out(rx1), .sym2_out(rx2), .blue_out(rx_b), .green_out(rx_g),
        .red_out(rx_r), .pix_count_out(rx_cnt));

    // System clock, and a free pixel clock offset so its edges never meet ours
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #3;
        forever #32 lclk = ~lclk;
    end

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Blanking token for a control pair, from the package table
    function automatic logic [9:0] tok(input logic [1:0] c);
        case (c)
            2'h0: return TOKEN_00;
            2'h1: return TOKEN_01;
            2'h2: return TOKEN_10;
            default: return TOKEN_11;
        endcase
    endfunction

    // Present one pixel just after a pixel clock fall, so it is settled well before the rise
    task automatic set_pix(input logic d, input logic [7:0] b, g, r, input logic h, v, input logic [2:0] a);
        @(negedge lclk);
        @(negedge clk);
        {de, blue, green, red, hs, vs, aux} = {d, b, g, r, h, v, a};
        repeat (20) @(negedge clk);
    endtask

    // Pin strapped mode: high pin runs the link
    task automatic t_pin_up();
        @(negedge clk) pdn = 1'b1;
        repeat (4) @(negedge clk);
        check(16'(pd), 16'h0);
        check(16'(oe), 16'h1);
    endtask

    // Two unlike pixels back to back land on the right channels
    task automatic t_video();
        set_pix(1'b1, 8'h3c, 8'ha5, 8'h0f, 1'b0, 1'b0, 3'h0);
        check(16'({rx_b, rx_r}), 16'h3c0f);
        check(16'(rx_g), 16'ha5);
        set_pix(1'b1, 8'hff, 8'h00, 8'h81, 1'b1, 1'b1, 3'h7);
        check(16'(rx_b), 16'hff);
        check(16'(rx_g), 16'h00);
        check(16'(rx_r), 16'h81);
    endtask

    // Every control pair on channels zero and two during blanking; channel one only sees 00 and 01
    task automatic t_blank();
        for (int i = 0; i < 4; i++) begin
            set_pix(1'b0, 8'hff, 8'hff, 8'hff, i[0], i[1], {i[0], i[1], i[0]});
            check(16'(rx0), 16'(tok(i[1:0])));
            check(16'(rx1), 16'(tok({1'b0, i[0]})));
            check(16'(rx2), 16'(tok({i[0], i[1]})));
        end
    endtask

    // Clock legs toggle and stay complementary while running
    task automatic t_clock();
        int rises;
        logic last;
        rises = 0;
        last = ckp;
        repeat (24) begin
            @(negedge clk);
            check(16'(ckn), 16'(!ckp));
            if (ckp && !last) begin
                rises++;
            end
            last = ckp;
        end
        check(16'(rises >= 2), 16'h1);
    endtask

    // Low pin quiets the whole link
    task automatic t_pin_down();
        @(negedge clk) pdn = 1'b0;
        repeat (4) @(negedge clk);
        check(16'(pd), 16'h1);
        check(16'({oe, ckp, ckn}), 16'h0);
        check(16'(ch0 | ch1 | ch2), 16'h0);
    endtask

    // One write while down: the bit shows one edge after the strobe, the state one edge later
    task automatic cfg_write(input logic v);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_run = v;
        @(negedge clk);
        cfg_wr = 1'b0;
        check(16'({cfg_run_o, pd}), 16'({v, 1'b1}));
        @(negedge clk);
        check(16'(pd), 16'(!v));
    endtask

    // Serial mode: pin held low by the board, register bit rules
    task automatic t_serial();
        logic [15:0] n;
        @(negedge clk) sel = 1'b1; // Pin stays grounded from here on
        repeat (4) @(negedge clk);
        check(16'({cfg_run_o, pd}), 16'h1);
        cfg_write(1'b1);
        n = rx_cnt;
        repeat (40) @(negedge clk);
        check(16'(rx_cnt > n + 16'h3), 16'h1);
        @(negedge clk) cfg_rst = 1'b1;
        @(negedge clk) cfg_rst = 1'b0;
        @(negedge clk);
        check(16'(cfg_run_o), 16'h0);
        @(negedge clk);
        check(16'({pd, oe}), 16'h2);
        cfg_write(1'b1);
        @(negedge clk) sel = 1'b0;
        repeat (4) @(negedge clk);
        check(16'(pd), 16'h1);
        @(negedge clk) sel = 1'b1;
        repeat (4) @(negedge clk);
        check(16'({cfg_run_o, pd}), 16'h1);
    endtask

    // Print the counts and the verdict, then stop
    task automatic give_verdict();
        $display("tests_run %0d fail_count %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs well under 20 us
    initial begin
        #200000;
        fail_count++;
        give_verdict();
    end

    // Main sequence; this block has no reserved or no-connect input to strap
    initial begin
        {rstn, pdn, sel, cfg_wr, cfg_run, cfg_rst, de, hs, vs} = 9'h000;
        {blue, green, red, aux} = 27'h0;
        repeat (4) @(negedge clk);
        check(16'({pd, cfg_run_o, oe}), 16'h4);
        rstn = 1'b1;
        t_pin_up();
        t_video();
        t_blank();
        t_clock();
        t_pin_down();
        t_serial();
        give_verdict();
    end
endmodule
`default_nettype wire

// >>> dvt_rx_model.sv
// Behavioural link receiver that captures and decodes the three channels
`timescale 1ns/1ps
`default_nettype none
module dvt_rx_model (
    // Clock
    input wire logic clk_in,
    // Link from the transmitter
    input wire logic [9:0] ch0_in,
    input wire logic [9:0] ch1_in,
    input wire logic [9:0] ch2_in,
    input wire logic clk_p_in,
    input wire logic oe_in,
    // Captured symbols and decoded bytes
    output logic [9:0] sym0_out,
    output logic [9:0] sym1_out,
    output logic [9:0] sym2_out,
    output logic [7:0] blue_out,
    output logic [7:0] green_out,
    output logic [7:0] red_out,
    output logic [15:0] pix_count_out
);
    logic clk_p_prev_r = 1'b0; // Clock leg one edge ago, for rise detection
    logic [15:0] cnt_r = 16'h0000; // Pixels captured so far

    assign pix_count_out = cnt_r;

    // Undo the transition coding of one active-video symbol
    function automatic logic [7:0] decode(input logic [9:0] q);
        logic [7:0] d;
        logic [7:0] o;
        d = q[9] ? ~q[7:0] : q[7:0];
        o[0] = d[0];
        for (int i = 1; i < 8; i++) begin
            o[i] = q[8] ? (d[i] ^ d[i-1]) : ~(d[i] ^ d[i-1]);
        end
        return o;
    endfunction

    // Capture on each rise of the forwarded clock; a quiet link captures nothing
    always @(posedge clk_in) begin
        if (oe_in && clk_p_in && !clk_p_prev_r) begin
            sym0_out <= ch0_in;
            sym1_out <= ch1_in;
            sym2_out <= ch2_in;
            blue_out <= decode(ch0_in);
            green_out <= decode(ch1_in);
            red_out <= decode(ch2_in);
            cnt_r <= cnt_r + 16'h0001;
        end
        clk_p_prev_r <= clk_p_in;
    end
endmodule
`default_nettype wire

// >>> dvt_tmds_enc.sv
// One link channel encoder: 8b/10b symbols for active video, tokens for blanking
`timescale 1ns/1ps
`default_nettype none
module dvt_tmds_enc (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Channel carrier
    dvt_enc_if.enc ch
);
    import dvt_pkg::*;

    logic [9:0] sym_r; // Symbol on the link
    logic [9:0] sym_nxt;
    logic signed [5:0] disp_r; // Running disparity
    logic signed [5:0] disp_nxt;
    logic [8:0] qm; // Transition-minimised word
    logic [3:0] n1d; // Ones in the input byte
    logic [3:0] n1q; // Ones in the minimised word
    logic [3:0] n0q; // Zeros in the minimised word
    logic signed [5:0] diff; // Ones minus zeros
    logic use_xnor;

    assign ch.sym = sym_r;

    // Symbol selection and disparity bookkeeping
    always_comb begin
        n1d = ones8(ch.data);
        use_xnor = (n1d > ONES_HALF) || ((n1d == ONES_HALF) && !ch.data[0]);
        qm = 9'h000;
        qm[0] = ch.data[0];
        for (int i = 1; i < COLOR_W; i++) begin
            qm[i] = use_xnor ? ~(qm[i-1] ^ ch.data[i]) : (qm[i-1] ^ ch.data[i]);
        end
        qm[8] = ~use_xnor;
        n1q = ones8(qm[7:0]);
        n0q = ONES_ALL - n1q;
        diff = $signed({2'h0, n1q}) - $signed({2'h0, n0q});
        if (!ch.de) begin
            // Blanking resets the disparity to zero
            sym_nxt = ctrl_token(ch.ctrl);
            disp_nxt = DISP_ZERO;
        end else if ((disp_r == DISP_ZERO) || (n1q == n0q)) begin
            sym_nxt = {~qm[8], qm[8], qm[8] ? qm[7:0] : ~qm[7:0]};
            disp_nxt = qm[8] ? (disp_r + diff) : (disp_r - diff);
        end else if ((!disp_r[5] && (n1q > n0q)) || (disp_r[5] && (n0q > n1q))) begin
            // Invert to pull the disparity back towards zero
            sym_nxt = {1'b1, qm[8], ~qm[7:0]};
            disp_nxt = disp_r + (qm[8] ? DISP_TWO : DISP_ZERO) - diff;
        end else begin
            sym_nxt = {1'b0, qm[8], qm[7:0]};
            disp_nxt = disp_r - (qm[8] ? DISP_ZERO : DISP_TWO) + diff;
        end
    end

    // Symbol register; clearing wins so nothing leaks out while powered down
    always_ff @(posedge clk_in) begin
        if (!rstn_in || ch.clear) begin
            sym_r <= SYM_IDLE;
            disp_r <= DISP_ZERO;
        end else if (ch.load) begin
            sym_r <= sym_nxt;
            disp_r <= disp_nxt;
        end
    end

endmodule
`default_nettype wire
